// file: src/perf_mode_pkg.sv
// Package for the monitor mode control register block.
// Assumes one 10 MHz processor clock and a core that drives the special
// register path and the machine state on that same clock.
package perf_mode_pkg;

	// Special register number of the mode control register
	localparam logic [9:0]  MODE_CONTROL_NUMBER = 10'h31B;
	localparam int          REGISTER_WIDTH      = 32;
	localparam logic [31:0] MODE_CONTROL_RESET  = 32'h0000_0000;

	// Field positions as vector indices; bit 0 of the register is index 31
	localparam int POS_GLOBAL_FREEZE       = 31;
	localparam int POS_SUPERVISOR_FREEZE   = 30;
	localparam int POS_USER_FREEZE         = 29;
	localparam int POS_MARKED_FREEZE       = 28;
	localparam int POS_UNMARKED_FREEZE     = 27;
	localparam int POS_EXCEPTION_ENABLE    = 26;
	localparam int POS_FREEZE_ON_INTERRUPT = 25;
	localparam int POS_TB_SELECT_HI        = 24;
	localparam int POS_TB_SELECT_LO        = 23;
	localparam int POS_TB_INTERRUPT_ENABLE = 22;
	localparam int POS_THRESHOLD_HI        = 21;
	localparam int POS_THRESHOLD_LO        = 16;
	localparam int POS_TRIGGER             = 13;

	// Threshold field width and its scale of eight cycles
	localparam int THRESHOLD_WIDTH = 6;
	localparam int THRESHOLD_SHIFT = 3;

	// Time base taps as vector indices; time base bit 63 is index 0
	localparam int TB_TAP_BIT63 = 0;
	localparam int TB_TAP_BIT55 = 8;
	localparam int TB_TAP_BIT51 = 12;
	localparam int TB_TAP_BIT47 = 16;

	// Time base select codes
	typedef enum logic [1:0] {
		TB_SEL_63 = 2'b00,
		TB_SEL_55 = 2'b01,
		TB_SEL_51 = 2'b10,
		TB_SEL_47 = 2'b11
	} tb_select_t;

	// One request on the special register path
	typedef struct packed {
		logic        read;
		logic        write;
		logic [9:0]  number;
		logic [31:0] data;
	} special_register_request_t;

	// Machine state bits that steer the freeze decode
	typedef struct packed {
		logic privilege_bit;
		logic process_mark_bit;
	} machine_state_word_t;

	// Freeze controls handed to the decode
	typedef struct packed {
		logic global_counter_freeze;
		logic supervisor_state_freeze;
		logic user_state_freeze;
		logic marked_process_freeze;
		logic unmarked_process_freeze;
	} freeze_controls_t;

endpackage

// file: src/time_base_tap.sv
// Picks one time base bit and reports its off-to-on transitions.
// Assumes the time base counts on the same clock as this block.
`timescale 1ns/10ps
module time_base_tap
	import perf_mode_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [63:0] time_base,
	input  wire tb_select_t  select,
	output logic             rising
);

	typedef struct packed {
		logic prev_bit;
		logic primed;
	} tap_state_t;

	tap_state_t state;
	tap_state_t next_state;
	logic       tapped;

	always_comb begin
		case (select)
			TB_SEL_63: tapped = time_base[TB_TAP_BIT63];
			TB_SEL_55: tapped = time_base[TB_TAP_BIT55];
			TB_SEL_51: tapped = time_base[TB_TAP_BIT51];
			TB_SEL_47: tapped = time_base[TB_TAP_BIT47];
			default:   tapped = time_base[TB_TAP_BIT63];
		endcase
	end

	// Primed keeps a set bit at reset release from looking like an edge
	always_comb begin
		next_state          = state;
		next_state.prev_bit = tapped;
		next_state.primed   = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// A change of select can show as an edge; that is accepted
	assign rising = state.primed & tapped & ~state.prev_bit;

endmodule

// file: src/freeze_decode.sv
// Combines every freeze condition into one counting permission.
// Assumes machine state bits are stable on the processor clock.
`timescale 1ns/10ps
module freeze_decode
	import perf_mode_pkg::*;
(
	input  wire freeze_controls_t    controls,
	input  wire machine_state_word_t machine_state_word,
	input  wire logic                interrupt_freeze,
	output logic                     counting_allowed
);

	logic blocked;

	always_comb begin
		blocked = 1'b0;
		if (controls.global_counter_freeze) begin
			blocked = 1'b1;
		end
		if (controls.supervisor_state_freeze && !machine_state_word.privilege_bit) begin
			blocked = 1'b1;
		end
		if (controls.user_state_freeze && machine_state_word.privilege_bit) begin
			blocked = 1'b1;
		end
		if (controls.marked_process_freeze && machine_state_word.process_mark_bit) begin
			blocked = 1'b1;
		end
		if (controls.unmarked_process_freeze && !machine_state_word.process_mark_bit) begin
			blocked = 1'b1;
		end
		if (interrupt_freeze) begin
			blocked = 1'b1;
		end
		counting_allowed = ~blocked;
	end

endmodule

// file: src/perf_mode_control.sv
// Monitor mode control register of the performance monitor, reached as a
// special register, with the counter freeze, interrupt signalling, time
// base interrupt and threshold logic that it steers.
// Assumes the core drives the special register path, the machine state,
// the counter top bits and the time base on this same clock.
`timescale 1ns/10ps
module perf_mode_control
	import perf_mode_pkg::*;
#(
	parameter int NUM_COUNTERS = 8
) (
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire special_register_request_t request,
	input  wire machine_state_word_t       machine_state_word,
	input  wire logic [NUM_COUNTERS-1:0]   counter_negative,
	input  wire logic [NUM_COUNTERS-1:0]   counter_interrupt_control,
	input  wire logic                      global_interrupt_enable,
	input  wire logic [63:0]               time_base,
	output logic [31:0]                    read_data,
	output logic                           read_valid,
	output logic                           write_done,
	output logic                           access_fault,
	output logic                           counter_update_enable,
	output logic                           monitor_interrupt,
	output logic                           interrupt_freeze,
	output logic [8:0]                     threshold_cycles
);

	// Whole state of the block in one record
	typedef struct packed {
		logic [31:0] mode_control;
		logic        interrupt_freeze;
		logic [31:0] read_data;
		logic        read_valid;
		logic        write_done;
		logic        access_fault;
		logic        counter_update_enable;
		logic        monitor_interrupt;
		logic [8:0]  threshold_cycles;
	} mode_state_t;

	mode_state_t state;
	mode_state_t next_state;

	// Address and privilege qualification
	logic selected;
	logic supervisor;
	logic read_taken;
	logic write_taken;

	// Current field views
	logic       exception_enable;
	logic       freeze_on_interrupt;
	logic       trigger;
	logic       tb_interrupt_enable;
	tb_select_t tb_select;

	// Interrupt causes
	logic counter_cause;
	logic tb_rising;
	logic tb_cause;
	logic cause_present;
	logic signal_now;

	// Freeze decode feeds
	freeze_controls_t next_controls;
	logic             next_counting_allowed;

	assign selected = (request.number == MODE_CONTROL_NUMBER);

	assign supervisor = ~machine_state_word.privilege_bit;

	// Read and write are taken only when selected and privileged
	assign read_taken  = request.read & selected & supervisor;
	assign write_taken = request.write & selected & supervisor;

	// Field views of the stored register
	assign exception_enable    = state.mode_control[POS_EXCEPTION_ENABLE];
	assign freeze_on_interrupt = state.mode_control[POS_FREEZE_ON_INTERRUPT];
	assign trigger             = state.mode_control[POS_TRIGGER];
	assign tb_interrupt_enable = state.mode_control[POS_TB_INTERRUPT_ENABLE];
	assign tb_select = tb_select_t'(state.mode_control[POS_TB_SELECT_HI:POS_TB_SELECT_LO]);

	// Edge source for the selected time base bit
	time_base_tap u_time_base_tap (
		.clock     (clock),
		.rst_n     (rst_n),
		.time_base (time_base),
		.select    (tb_select),
		.rising    (tb_rising)
	);

	assign counter_cause = (|(counter_negative & counter_interrupt_control))
		& global_interrupt_enable;

	assign tb_cause = tb_rising & tb_interrupt_enable & global_interrupt_enable;

	assign cause_present = counter_cause | tb_cause;

	assign signal_now = cause_present & exception_enable;

	// Next state of every register
	always_comb begin
		next_state = state;

		// One-cycle answers fall back each cycle
		next_state.read_valid        = 1'b0;
		next_state.write_done        = 1'b0;
		next_state.access_fault      = 1'b0;
		next_state.monitor_interrupt = 1'b0;

		if (read_taken) begin
			next_state.read_data  = state.mode_control;
			next_state.read_valid = 1'b1;
		end

		// Selected but not privileged: refused, nothing stored
		if ((request.read | request.write) & selected & ~supervisor) begin
			next_state.access_fault = 1'b1;
		end

		// Software write replaces the whole register
		if (write_taken) begin
			next_state.mode_control = request.data;
			next_state.write_done   = 1'b1;
			next_state.interrupt_freeze = 1'b0;
		end

		// Interrupt signalling and its side effects
		if (signal_now) begin
			next_state.monitor_interrupt = 1'b1;
			next_state.mode_control[POS_EXCEPTION_ENABLE] = 1'b0;
			if (freeze_on_interrupt && !trigger) begin
				// Set wins over a software reset in the same cycle
				next_state.interrupt_freeze = 1'b1;
			end
		end

		// hardware leaves the time base enable alone: only writes above touch it

		next_state.threshold_cycles = {
			next_state.mode_control[POS_THRESHOLD_HI:POS_THRESHOLD_LO],
			{THRESHOLD_SHIFT{1'b0}}
		};

		next_state.counter_update_enable = next_counting_allowed;
	end

	// Freeze controls taken from the register value about to be stored
	always_comb begin
		next_controls.global_counter_freeze =
			next_state.mode_control[POS_GLOBAL_FREEZE];
		next_controls.supervisor_state_freeze =
			next_state.mode_control[POS_SUPERVISOR_FREEZE];
		next_controls.user_state_freeze =
			next_state.mode_control[POS_USER_FREEZE];
		next_controls.marked_process_freeze =
			next_state.mode_control[POS_MARKED_FREEZE];
		next_controls.unmarked_process_freeze =
			next_state.mode_control[POS_UNMARKED_FREEZE];
	end

	// Permission is registered so the counters see a clean level;
	// the price is one cycle from a state change to its effect
	freeze_decode u_freeze_decode (
		.controls           (next_controls),
		.machine_state_word (machine_state_word),
		.interrupt_freeze   (next_state.interrupt_freeze),
		.counting_allowed   (next_counting_allowed)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state                       <= '0;
			state.mode_control          <= MODE_CONTROL_RESET;
			state.counter_update_enable <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Outputs come straight from the state record
	assign read_data             = state.read_data;
	assign read_valid            = state.read_valid;
	assign write_done            = state.write_done;
	assign access_fault          = state.access_fault;
	assign counter_update_enable = state.counter_update_enable;
	assign monitor_interrupt     = state.monitor_interrupt;
	assign interrupt_freeze      = state.interrupt_freeze;
	assign threshold_cycles      = state.threshold_cycles;

endmodule

// file: verification/perf_mode_control_assertions.sv
// Port checker for the mode control register block.
// Assumes the single processor clock and the active-low reset.
`timescale 1ns/10ps
module perf_mode_control_assertions
	import perf_mode_pkg::*;
#(
	parameter int NUM_COUNTERS = 8
) (
	input wire logic                      clock,
	input wire logic                      rst_n,
	input wire special_register_request_t request,
	input wire machine_state_word_t       machine_state_word,
	input wire logic [NUM_COUNTERS-1:0]   counter_negative,
	input wire logic [NUM_COUNTERS-1:0]   counter_interrupt_control,
	input wire logic                      global_interrupt_enable,
	input wire logic [63:0]               time_base,
	input wire logic [31:0]               read_data,
	input wire logic                      read_valid,
	input wire logic                      write_done,
	input wire logic                      access_fault,
	input wire logic                      counter_update_enable,
	input wire logic                      monitor_interrupt,
	input wire logic                      interrupt_freeze,
	input wire logic [8:0]                threshold_cycles
);
	// Access decode; user state turns a hit into a fault
	logic hit;
	logic user;
	logic taken_write;
	assign hit = (request.read || request.write) && request.number == MODE_CONTROL_NUMBER;
	assign user = machine_state_word.privilege_bit;
	assign taken_write = hit && request.write && !user;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_read_answer: assert property (hit && request.read && !user |=> read_valid)
		else $error("read not answered");
	a_user_fault: assert property (hit && user |=>
		access_fault && !read_valid && !write_done)
		else $error("user access not refused");
	a_other_number: assert property (!hit |=> !read_valid && !write_done && !access_fault)
		else $error("foreign number answered");
	a_threshold_scale: assert property (taken_write |=>
		threshold_cycles == {$past(request.data[21:16]), 3'b000})
		else $error("threshold not scaled by eight");
	a_global_freeze: assert property (taken_write && request.data[31] |=>
		!counter_update_enable)
		else $error("global freeze ignored");
	a_supervisor_freeze: assert property (taken_write && request.data[30] |=>
		!counter_update_enable)
		else $error("supervisor freeze ignored");
	a_freeze_holds: assert property (interrupt_freeze |-> !counter_update_enable)
		else $error("counting during interrupt freeze");
	a_interrupt_cause: assert property (monitor_interrupt |-> $past(global_interrupt_enable))
		else $error("interrupt without global enable");
	a_interrupt_once: assert property (monitor_interrupt ##1 !write_done ##1 !write_done
		|-> !monitor_interrupt)
		else $error("interrupt repeated without rearm");
endmodule

bind perf_mode_control perf_mode_control_assertions #(.NUM_COUNTERS(NUM_COUNTERS)) checker_u (
	.clock(clock), .rst_n(rst_n), .request(request), .machine_state_word(machine_state_word),
	.counter_negative(counter_negative), .counter_interrupt_control(counter_interrupt_control),
	.global_interrupt_enable(global_interrupt_enable), .time_base(time_base),
	.read_data(read_data), .read_valid(read_valid), .write_done(write_done),
	.access_fault(access_fault), .counter_update_enable(counter_update_enable),
	.monitor_interrupt(monitor_interrupt), .interrupt_freeze(interrupt_freeze),
	.threshold_cycles(threshold_cycles));

// file: verification/core_time_base.sv
// Core time base model: free-running 64-bit count with a load.
// Assumes the bench loads it on the shared clock.
`timescale 1ns/10ps
module core_time_base (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        load,
	input  wire logic [63:0] load_value,
	output logic [63:0]      time_base
);
	// Counting for real so every tap sees true transitions
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			time_base <= 64'h0;
		end else begin
			time_base <= load ? load_value : time_base + 64'h1;
		end
	end
endmodule

// file: verification/perf_mode_control_bench.sv
// Self-checking bench for the mode control register block.
// Assumes a 10 MHz clock and the time base model beside it.
`timescale 1ns/10ps
`define CHECK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end
module perf_mode_control_bench
	import perf_mode_pkg::*;
;
	logic                      clock = 1'b0;
	logic                      rst_n = 1'b0;
	special_register_request_t request = '0;
	machine_state_word_t       machine_state_word = '0;
	logic [7:0]                counter_negative = 8'h00;
	logic [7:0]                counter_interrupt_control = 8'h00;
	logic                      global_interrupt_enable = 1'b0;
	logic                      tb_load = 1'b0;
	logic [63:0]               tb_load_value = 64'h0;
	logic [63:0]               time_base;
	logic [31:0]               read_data;
	logic [8:0]                threshold_cycles;
	logic                      read_valid;
	logic                      write_done;
	logic                      access_fault;
	logic                      counter_update_enable;
	logic                      monitor_interrupt;
	logic                      interrupt_freeze;
	int                        bad_count = 0;
	int                        comparisons = 0;
	int                        cycles = 0;
	logic [2:0]                flags;
	logic [31:0]               rdata;

	perf_mode_control dut_u (.clock(clock), .rst_n(rst_n), .request(request),
		.machine_state_word(machine_state_word), .counter_negative(counter_negative),
		.counter_interrupt_control(counter_interrupt_control),
		.global_interrupt_enable(global_interrupt_enable), .time_base(time_base),
		.read_data(read_data), .read_valid(read_valid), .write_done(write_done),
		.access_fault(access_fault), .counter_update_enable(counter_update_enable),
		.monitor_interrupt(monitor_interrupt), .interrupt_freeze(interrupt_freeze),
		.threshold_cycles(threshold_cycles));
	core_time_base tb_u (.clock(clock), .rst_n(rst_n), .load(tb_load),
		.load_value(tb_load_value), .time_base(time_base));

	always #50 clock = ~clock;

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic summarize();
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One request cycle; answers are looked at one edge later
	task automatic access(input logic rd, input logic wr, input logic [9:0] num,
		input logic [31:0] data);
		@(posedge clock);
		request <= '{rd, wr, num, data};
		@(posedge clock);
		request <= '0;
		#1;
		flags = {read_valid, write_done, access_fault};
		rdata = read_data;
	endtask

	task automatic wr_word(input logic [31:0] d);
		access(1'b0, 1'b1, MODE_CONTROL_NUMBER, d);
		`CHECK("write answer", 3'b010, flags)
	endtask

	task automatic rd_expect(input logic [31:0] e);
		access(1'b1, 1'b0, MODE_CONTROL_NUMBER, 32'h0);
		`CHECK("read answer", 3'b100, flags)
		`CHECK("register", e, rdata)
	endtask

	// refusals, foreign number, read with write
	task automatic check_access();
		wr_word(32'h5A3F_A5C3);
		`CHECK("threshold", 9'h1F8, threshold_cycles)
		rd_expect(32'h5A3F_A5C3);
		@(posedge clock);
		machine_state_word <= 2'b10;
		access(1'b1, 1'b1, MODE_CONTROL_NUMBER, 32'h0);
		`CHECK("user access", 3'b001, flags)
		`CHECK("user data", 32'h5A3F_A5C3, rdata)
		@(posedge clock);
		machine_state_word <= 2'b00;
		access(1'b1, 1'b1, 10'h31C, 32'h0);
		`CHECK("other number", 3'b000, flags)
		access(1'b1, 1'b1, MODE_CONTROL_NUMBER, 32'h0);
		`CHECK("old value", 32'h5A3F_A5C3, rdata)
		rd_expect(32'h0000_0000);
	endtask

	// each freeze bit against each machine state
	task automatic check_freeze();
		logic f;
		for (int b = 0; b < 5; b++) begin
			for (int m = 0; m < 4; m++) begin
				wr_word(32'h8000_0000 >> b);
				@(posedge clock);
				machine_state_word <= 2'(m);
				repeat (2) @(posedge clock);
				#1;
				f = b == 0 || (b == 1 && m < 2) || (b == 2 && m > 1) || (b == 3 && m[0])
					|| (b == 4 && !m[0]);
				`CHECK("update enable", !f, counter_update_enable)
				@(posedge clock);
				machine_state_word <= 2'b00;
			end
		end
	endtask

	// time base edge on every tap
	task automatic check_time_base();
		int          taps [4] = '{0, 8, 12, 16};
		logic [31:0] w;
		int          n;
		for (int s = 0; s < 4; s++) begin
			// software drops the time base enable after each interrupt
			wr_word(32'h0000_0000);
			w = 32'h0440_0000 | 32'(s) << 23 | 32'(s & 1) << 25 | 32'(s >> 1) << 13;
			@(posedge clock);
			global_interrupt_enable <= 1'b1;
			tb_load <= 1'b1;
			tb_load_value <= (64'h1 << taps[s]) - 64'h10;
			@(posedge clock);
			tb_load <= 1'b0;
			wr_word(w);
			for (n = 0; n < 40 && monitor_interrupt !== 1'b1; n++) begin
				@(posedge clock);
				#1;
			end
			`CHECK("interrupt", 1'b1, monitor_interrupt)
			`CHECK("freeze", s == 1, interrupt_freeze)
			`CHECK("update enable", s != 1, counter_update_enable)
			rd_expect(w & 32'hFBFF_FFFF);
		end
	endtask

	// counter cause under every enable mix, time base edges unarmed
	task automatic check_counter_cause();
		int hits;
		@(posedge clock);
		counter_negative <= 8'h81;
		for (int c = 0; c < 8; c++) begin
			wr_word(32'h0000_0000);
			@(posedge clock);
			global_interrupt_enable <= c[0];
			counter_interrupt_control <= c[1] ? 8'h01 : 8'h00;
			wr_word(c[2] ? 32'h0400_0000 : 32'h0000_0000);
			hits = 0;
			repeat (6) begin
				@(posedge clock);
				#1;
				hits += int'(monitor_interrupt === 1'b1);
			end
			`CHECK("interrupt count", c == 7 ? 1 : 0, hits)
		end
	endtask

	// a reset in mid-run clears a written register
	task automatic check_reset();
		wr_word(32'h8060_0000);
		`CHECK("threshold", 9'h100, threshold_cycles)
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		`CHECK("update enable", 1'b1, counter_update_enable)
		`CHECK("threshold", 9'h000, threshold_cycles)
		rd_expect(32'h0000_0000);
	endtask

	// Main sequence, starting with the power-up values
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		`CHECK("update enable", 1'b1, counter_update_enable)
		rd_expect(32'h0000_0000);
		check_access();
		check_freeze();
		check_time_base();
		check_counter_cause();
		check_reset();
		summarize();
	end
endmodule
